// *** hdl/vrsc_pkg.sv ***
package vrsc_pkg;
  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int CODE_W = 8;
  localparam int REF_W  = 8;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ        = 25_000_000;
  localparam int SAMPLE_HZ     = 3_000_000;
  localparam int STEP_HZ       = 330_000;
  localparam int SAMPLE_DIV    = CLK_HZ / SAMPLE_HZ;
  localparam int STEP_DIV      = CLK_HZ / STEP_HZ;
  localparam int DIV_W         = 8;
  localparam int STABLE_COUNT  = 3;
  localparam int STEP_UV       = 6250;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [CODE_W-1:0] CODE_RESET = 8'h00;
  localparam logic [REF_W-1:0]  REF_RESET  = 8'h00;
  localparam logic [REF_W-1:0]  REF_ONE    = 8'h01;
endpackage

// *** hdl/vrsc_divider.sv ***
`timescale 1ns/1ps
module vrsc_divider #(
  parameter logic [vrsc_pkg::DIV_W-1:0] DIV = 8'h01
) (
  input  wire logic clk,
  input  wire logic reset,
  output logic      tick
);
  logic [vrsc_pkg::DIV_W-1:0] count_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_q <= '0;
      tick    <= 1'b0;
    end else if (count_q == DIV - 8'h01) begin
      count_q <= '0;
      tick    <= 1'b1;
    end else begin
      count_q <= count_q + 8'h01;
      tick    <= 1'b0;
    end
  end
endmodule // vrsc_divider

// *** hdl/vrsc_reference_slew.sv ***
`timescale 1ns/1ps
// Summary of operation
// - the code inputs are sampled on each 3MHz sample tick in either mode.
// - a changed code is accepted only after three consecutive equal samples.
// - in jump mode a validated code is copied straight into the reference.
// - in slew mode the reference moves one 6.25mV step per 330kHz tick until equal.
// - the jump or slew response follows the selected table mode.
module vrsc_reference_slew (
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire logic [vrsc_pkg::CODE_W-1:0] voltageCodeInputs,
  input  wire logic                        slewMode,
  output logic      [vrsc_pkg::CODE_W-1:0] acceptedCode,
  output logic      [vrsc_pkg::REF_W-1:0]  referenceLevel,
  output logic                             slewing,
  output logic                             codeValid
);
  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [vrsc_pkg::CODE_W-1:0] codeMeta_q;
  logic [vrsc_pkg::CODE_W-1:0] codeSync_q;
  logic                        modeMeta_q;
  logic                        modeSync_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      codeMeta_q <= vrsc_pkg::CODE_RESET;
      codeSync_q <= vrsc_pkg::CODE_RESET;
      modeMeta_q <= 1'b0;
      modeSync_q <= 1'b0;
    end else begin
      codeMeta_q <= voltageCodeInputs;
      codeSync_q <= codeMeta_q;
      modeMeta_q <= slewMode;
      modeSync_q <= modeMeta_q;
    end
  end

  // ------------------------------------------------------------
  // rate enables
  // ------------------------------------------------------------
  logic sampleTick;
  logic stepTick;

  vrsc_divider #(.DIV(8'(vrsc_pkg::SAMPLE_DIV))) u_sampleDiv (
    .clk   (clk),
    .reset (reset),
    .tick  (sampleTick)
  );

  vrsc_divider #(.DIV(8'(vrsc_pkg::STEP_DIV))) u_stepDiv (
    .clk   (clk),
    .reset (reset),
    .tick  (stepTick)
  );

  // ------------------------------------------------------------
  // code qualification
  // ------------------------------------------------------------
  // a glitch shorter than three samples never reaches the reference
  logic [vrsc_pkg::CODE_W-1:0] candidate_q;
  logic [1:0]                  stableCnt_q;
  logic                        validPulse_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      candidate_q  <= vrsc_pkg::CODE_RESET;
      stableCnt_q  <= 2'h0;
      acceptedCode <= vrsc_pkg::CODE_RESET;
      validPulse_q <= 1'b0;
    end else begin
      validPulse_q <= 1'b0;
      if (sampleTick) begin
        if (codeSync_q != candidate_q) begin
          candidate_q <= codeSync_q;
          stableCnt_q <= 2'h1;
        end else if (stableCnt_q < 2'(vrsc_pkg::STABLE_COUNT)) begin
          stableCnt_q <= stableCnt_q + 2'h1;
          if (stableCnt_q == 2'(vrsc_pkg::STABLE_COUNT - 1) &&
              candidate_q != acceptedCode) begin
            acceptedCode <= candidate_q;
            validPulse_q <= 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      codeValid <= 1'b0;
    end else begin
      codeValid <= validPulse_q;
    end
  end

  // ------------------------------------------------------------
  // reference update
  // ------------------------------------------------------------
  // the code maps one to one onto reference steps of 6.25mV each
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      referenceLevel <= vrsc_pkg::REF_RESET;
    end else if (!modeSync_q) begin
      referenceLevel <= acceptedCode;
    end else if (stepTick && referenceLevel != acceptedCode) begin
      if (referenceLevel < acceptedCode) begin
        referenceLevel <= referenceLevel + vrsc_pkg::REF_ONE;
      end else begin
        referenceLevel <= referenceLevel - vrsc_pkg::REF_ONE;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      slewing <= 1'b0;
    end else begin
      slewing <= modeSync_q && (referenceLevel != acceptedCode);
    end
  end
endmodule // vrsc_reference_slew

// *** sim/vrsc_reference_slew_properties.sv ***
`timescale 1ns/1ps
module vrsc_checker (
  input wire logic       clk, reset, slewMode, slewing, codeValid,
  input wire logic [7:0] voltageCodeInputs, acceptedCode, referenceLevel
);
  logic [7:0] stab, gap;
  logic       stp;
  // stp marks that the last reference move was a slew step, so any move after a slew step, a jump included, feeds the rate check
  always_ff @(posedge clk or posedge reset)
    if (reset) stab <= 8'h00;
    else stab <= $changed(voltageCodeInputs) ? 8'h00 : stab + 8'(stab != 8'hff);
  always_ff @(posedge clk or posedge reset)
    if (reset) gap <= 8'h00;
    else gap <= $changed(referenceLevel) ? 8'h00 : gap + 8'(gap != 8'hff);
  always_ff @(posedge clk or posedge reset)
    if (reset) stp <= 1'b0;
    else if ($changed(referenceLevel)) stp <= slewing;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_accept; $changed(acceptedCode) |-> stab >= 8'h10 && voltageCodeInputs == acceptedCode; endproperty
  a_accept: assert property (p_accept) else $error("code taken too early");
  property p_jump; (!slewMode)[*4] ##0 $changed(acceptedCode) |=> referenceLevel == acceptedCode; endproperty
  a_jump: assert property (p_jump) else $error("jump missed");
  property p_valid; $changed(acceptedCode) |-> ##[1:2] codeValid; endproperty
  a_valid: assert property (p_valid) else $error("no valid pulse");
  property p_pulse; codeValid |=> !codeValid; endproperty
  a_pulse: assert property (p_pulse) else $error("valid too long");
  property p_step; slewMode[*4] ##0 $changed(referenceLevel) |-> (referenceLevel - $past(referenceLevel)) inside {8'h01, 8'hff}; endproperty
  a_step: assert property (p_step) else $error("bad step size");
  property p_rate; $changed(referenceLevel) && stp |-> gap >= 8'h4a; endproperty
  a_rate: assert property (p_rate) else $error("steps too close");
  property p_stop; slewMode[*4] ##0 referenceLevel == acceptedCode ##1 $stable(acceptedCode) |-> $stable(referenceLevel); endproperty
  a_stop: assert property (p_stop) else $error("moved past target");
  property p_slewing; slewMode[*4] ##0 (referenceLevel != acceptedCode)[*2] |-> slewing; endproperty
  a_slewing: assert property (p_slewing) else $error("slewing low");
endmodule // vrsc_checker
bind vrsc_reference_slew vrsc_checker vrsc_checker_inst (.clk, .reset, .slewMode, .slewing,
  .codeValid, .voltageCodeInputs, .acceptedCode, .referenceLevel);

// *** sim/vrsc_cpu_model.sv ***
`timescale 1ns/1ps
module vrsc_cpu_model (
  input wire logic       clk, slewMode, glitch,
  input wire logic [7:0] targetCode,
  output logic     [7:0] voltageCodeInputs
);
  logic [7:0] code = 8'h00;
  logic [5:0] t = 6'h00;
  always @(posedge clk) begin
    t <= #1 (t == 6'h31) ? 6'h00 : t + 6'h01;
    if (slewMode) code <= #1 targetCode;
    else if (t == 6'h00 && code != targetCode) code <= #1 code + ((code < targetCode) ? 8'h01 : 8'hff);
  end
  assign voltageCodeInputs = glitch ? ~code : code;
endmodule // vrsc_cpu_model

// *** sim/vid_reference_slew_control_tb.sv ***
`timescale 1ns/1ps
module vid_reference_slew_control_tb;
  logic       clk = 1'b0, reset = 1'b1, slewMode = 1'b0, glitch = 1'b0, slewing, codeValid;
  logic [7:0] targetCode = 8'h00, voltageCodeInputs, acceptedCode, referenceLevel, cur;
  logic [7:0] q[$];
  integer     seed = 54710;
  int         fails = 0, n_checks = 0, i;
  always #20 clk = ~clk;
  vrsc_cpu_model vrsc_cpu_model_inst (.clk, .slewMode, .glitch, .targetCode, .voltageCodeInputs);
  vrsc_reference_slew vrsc_reference_slew_inst (.clk, .reset, .voltageCodeInputs, .slewMode,
    .acceptedCode, .referenceLevel, .slewing, .codeValid);
  task automatic check(input logic [7:0] seen, exp, input string what);
    n_checks++;
    if (seen !== exp) begin fails++; $display("BAD %s exp %h seen %h", what, exp, seen); end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic settle(input int n);
    for (int k = 0; k < n && (q.size() != 0 || referenceLevel !== targetCode); k++) @(posedge clk);
    #1;
  endtask
  // every validated code must match the oldest expected one
  // look just after the edge so the pulse launched there is seen, not the value before it
  always @(posedge clk) begin
    #1;
    if (codeValid === 1'b1) begin
      if (q.size() == 0) check(8'h01, 8'h00, "codeValid");
      else check(acceptedCode, q.pop_front(), "acceptedCode");
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    #1 reset = 1'b0;
    for (i = 0; i < 6; i++) begin
      if (i == 3) slewMode = 1'b1;
      cur = targetCode;
      targetCode = (i < 3) ? cur + (8'($random(seed)) & 8'h03) + 8'h01 : 8'($random(seed));
      if (i < 3) while (cur != targetCode) begin cur++; q.push_back(cur); end
      else if (targetCode != cur) q.push_back(targetCode);
      if (i == 5) begin
        repeat (300) @(posedge clk);
        #1 targetCode ^= 8'h80;
        q.push_back(targetCode);
        repeat (60) @(posedge clk);
        #1 check({7'h00, slewing}, 8'h01, "slewing");
      end
      settle(20000);
      check(referenceLevel, targetCode, "referenceLevel");
      @(posedge clk);
      #1 check({7'h00, slewing}, 8'h00, "slewing");
    end
    glitch = 1'b1;
    repeat (12) @(posedge clk);
    #1 glitch = 1'b0;
    repeat (40) @(posedge clk);
    check(acceptedCode, targetCode, "acceptedCode");
    print_verdict;
  end
  initial begin #(40 * 95000); fails++; print_verdict; end
endmodule // vid_reference_slew_control_tb
